/* design/eirq_detector.sv */
// Purpose: pin interrupt detector with one 8-bit status/control register
// Assumes: CPU reaches the register by a write strobe and a read strobe
// Notes:   read data is registered, so it is valid the cycle after the read strobe;
//          each group of state has its own next-value and register process;
//          the pin sees four cycles of synchroniser latency before any decode
`include "eirq_consts.svh"
`default_nettype none
module eirq_detector
    import eirq_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_pin,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_irq_req,
    output logic      [7:0]  o_vector_num,
    output logic      [15:0] o_vector_addr,
    output logic             o_pull_up_en,
    output logic             o_pull_down_en
);
    // -------------------------------------------------------------
    // pin synchroniser
    // -------------------------------------------------------------
    logic pin_lvl;

    eirq_sync u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_pin),
        .o_level (pin_lvl)
    );

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic       pull_device_disable_q, pull_device_disable_d;
    logic       polarity_select_q,     polarity_select_d;
    logic       pin_function_enable_q, pin_function_enable_d;
    logic       event_flag_q,          event_flag_d;
    logic       request_enable_q,      request_enable_d;
    logic       detection_mode_q,      detection_mode_d;
    logic       prev_asserted_q,       prev_asserted_d;
    logic [7:0] rdata_q,               rdata_d;
    logic       irq_q,                 irq_d;
    logic       pull_up_q,             pull_up_d;
    logic       pull_down_q,           pull_down_d;
    eirq_pull_t pull_sel;
    logic       asserted;
    logic       edge_seen;
    logic       level_hold;
    logic       set_evt;
    logic       ack;

    // -------------------------------------------------------------
    // detection
    // -------------------------------------------------------------
    // pure decode of the filtered pin, it holds no state of its own;
    // the edge compares two filtered samples, so a pulse shorter than
    // the synchroniser's agreement window never reaches the flag
    always_comb begin
        // polarity maps the pin onto an asserted level
        asserted   = polarity_select_q ? pin_lvl : ~pin_lvl;
        // limitation: flipping polarity while enabled can read as a fresh edge
        edge_seen  = asserted & ~prev_asserted_q;
        // sustained level only counts in edge-and-level mode
        level_hold = detection_mode_q & asserted;
        set_evt    = pin_function_enable_q & (edge_seen | level_hold);
        ack        = i_reg_wr & i_reg_wdata[`EIRQ_BIT_ACK];
    end

    // -------------------------------------------------------------
    // control bits
    // -------------------------------------------------------------
    // a write reloads every control bit at once; bits 7, 3 and 2 keep no state
    // trade-off: the register is one byte, so no partial update is offered
    always_comb begin
        pull_device_disable_d = pull_device_disable_q;
        polarity_select_d     = polarity_select_q;
        pin_function_enable_d = pin_function_enable_q;
        request_enable_d      = request_enable_q;
        detection_mode_d      = detection_mode_q;
        // the write strobe is a one-cycle pulse, so each write lands once
        if (i_reg_wr) begin
            pull_device_disable_d = i_reg_wdata[`EIRQ_BIT_PULL_DIS];
            polarity_select_d     = i_reg_wdata[`EIRQ_BIT_POLARITY];
            pin_function_enable_d = i_reg_wdata[`EIRQ_BIT_PIN_EN];
            request_enable_d      = i_reg_wdata[`EIRQ_BIT_REQ_EN];
            detection_mode_d      = i_reg_wdata[`EIRQ_BIT_MODE];
        end
    end

    // control registers only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pull_device_disable_q <= 1'b0;
            polarity_select_q     <= 1'b0;
            pin_function_enable_q <= 1'b0;
            request_enable_q      <= 1'b0;
            detection_mode_q      <= 1'b0;
        end else begin
            pull_device_disable_q <= pull_device_disable_d;
            polarity_select_q     <= polarity_select_d;
            pin_function_enable_q <= pin_function_enable_d;
            request_enable_q      <= request_enable_d;
            detection_mode_q      <= detection_mode_d;
        end
    end

    // -------------------------------------------------------------
    // event flag and request
    // -------------------------------------------------------------
    // a set in the acknowledge cycle wins, which also keeps a held level latched
    always_comb begin
        if (set_evt) begin
            event_flag_d = 1'b1;
        end else if (ack) begin
            event_flag_d = 1'b0;
        end else begin
            event_flag_d = event_flag_q;
        end
        // history is parked at asserted while the pin function is off, so enabling
        // on an already asserted pin gives no edge; a held level still counts in mode 1
        prev_asserted_d = pin_function_enable_q ? asserted : 1'b1;
        // request from the next flag, so it rises in the same cycle as the flag
        irq_d = event_flag_d & request_enable_d;
    end

    // event registers only; switching the pin off keeps a pending flag
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            event_flag_q    <= 1'b0;
            prev_asserted_q <= 1'b1;  // no false edge right after enable
            irq_q           <= 1'b0;
        end else begin
            event_flag_q    <= event_flag_d;
            prev_asserted_q <= prev_asserted_d;
            irq_q           <= irq_d;
        end
    end

    // -------------------------------------------------------------
    // pull device
    // -------------------------------------------------------------
    // follows the control bits being written, so the pad changes with the write
    always_comb begin
        if (!pin_function_enable_d || pull_device_disable_d) begin
            pull_sel = EIRQ_PULL_NONE;
        end else if (polarity_select_d) begin
            pull_sel = EIRQ_PULL_DOWN;
        end else begin
            pull_sel = EIRQ_PULL_UP;
        end
        pull_up_d   = (pull_sel == EIRQ_PULL_UP);
        pull_down_d = (pull_sel == EIRQ_PULL_DOWN);
    end

    // pull registers only; the pad enables never glitch
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pull_up_q   <= 1'b0;
            pull_down_q <= 1'b0;
        end else begin
            pull_up_q   <= pull_up_d;
            pull_down_q <= pull_down_d;
        end
    end

    // -------------------------------------------------------------
    // read data
    // -------------------------------------------------------------
    // registered so the bus sees a clean value the cycle after the strobe;
    // a read and a write in one cycle return the old contents
    always_comb begin
        rdata_d = rdata_q;
        if (i_reg_rd) begin
            // acknowledge bit and bit 7 always read as zero
            rdata_d = 8'h00;
            rdata_d[`EIRQ_BIT_PULL_DIS] = pull_device_disable_q;
            rdata_d[`EIRQ_BIT_POLARITY] = polarity_select_q;
            rdata_d[`EIRQ_BIT_PIN_EN]   = pin_function_enable_q;
            rdata_d[`EIRQ_BIT_FLAG]     = event_flag_q;
            rdata_d[`EIRQ_BIT_REQ_EN]   = request_enable_q;
            rdata_d[`EIRQ_BIT_MODE]     = detection_mode_q;
        end
    end

    // read register only; holds until the next read
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= `EIRQ_RESET_VALUE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    logic [7:0]  vec_num_d;
    logic [15:0] vec_addr_d;

    // vector slot is fixed, carried for the interrupt arbiter
    // so it needs no table of its own
    always_comb begin
        vec_num_d  = `EIRQ_VECTOR_NUM;
        vec_addr_d = `EIRQ_VECTOR_ADDR;
    end

    // vector registers only; a constant needs no reset
    always_ff @(posedge i_clk) begin
        o_vector_num  <= vec_num_d;
        o_vector_addr <= vec_addr_d;
    end

    // every pad and the request leave straight from a flip-flop
    assign o_reg_rdata    = rdata_q;
    assign o_irq_req      = irq_q;
    assign o_pull_up_en   = pull_up_q;
    assign o_pull_down_en = pull_down_q;
endmodule
`default_nettype wire

/* design/eirq_sync.sv */
// Purpose: three-stage synchroniser with agreement on stages two and three
// Assumes: asynchronous pin level, single bus clock
// Notes:   stage one feeds only stage two
`default_nettype none
module eirq_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic s1_d, s2_d, s3_d, lvl_d;

    // -------------------------------------------------------------
    // next values
    // -------------------------------------------------------------
    always_comb begin
        s1_d  = i_async;
        s2_d  = s1_q;
        s3_d  = s2_q;
        // change counts only once stages two and three agree
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end

    // registers only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;
endmodule
`default_nettype wire

/* shared/eirq_consts.svh */
// Purpose: constants for the external interrupt-request pin detector
// Assumes: one 8-bit status/control register reached by its documented port
// Notes:   bit positions, reset value and vector slot live here
`ifndef EIRQ_CONSTS_SVH
`define EIRQ_CONSTS_SVH

// -----------------------------------------------------------------
// register field positions
// -----------------------------------------------------------------
`define EIRQ_BIT_PULL_DIS   6
`define EIRQ_BIT_POLARITY   5
`define EIRQ_BIT_PIN_EN     4
`define EIRQ_BIT_FLAG       3
`define EIRQ_BIT_ACK        2
`define EIRQ_BIT_REQ_EN     1
`define EIRQ_BIT_MODE       0

// -----------------------------------------------------------------
// reset value and vector slot
// -----------------------------------------------------------------
`define EIRQ_RESET_VALUE    8'h00
`define EIRQ_VECTOR_NUM     8'h02
`define EIRQ_VECTOR_ADDR    16'hfffa

`endif

/* shared/eirq_pkg.sv */
// Purpose: types for the external interrupt-request pin detector
// Assumes: nothing beyond the constants header
// Notes:   pull device state encoding
`default_nettype none
package eirq_pkg;
    // pull device driven onto the pad
    typedef enum logic [1:0] {
        EIRQ_PULL_NONE = 2'h0,
        EIRQ_PULL_UP   = 2'h1,
        EIRQ_PULL_DOWN = 2'h2
    } eirq_pull_t;
endpackage
`default_nettype wire

/* verif/eirq_detector_chk.sv */
// Purpose: port checker for the pin interrupt detector
// Assumes: c_q shadows the written control bits
// Notes:   the flag shows only through requests and reads
`default_nettype none
module eirq_detector_chk (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_pin,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_irq_req,
    input wire logic [7:0]  o_vector_num,
    input wire logic [15:0] o_vector_addr,
    input wire logic        o_pull_up_en,
    input wire logic        o_pull_down_en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] c_q;
    // shadow of writable bits; ack and flag never stick
    always_ff @(posedge i_clk) c_q <= i_rst ? 8'h00 : (i_reg_wr ? (i_reg_wdata & 8'h73) : c_q);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_pull_up_cfg: assert property (o_pull_up_en == (c_q[4] & ~c_q[6] & ~c_q[5]))
        else $error("pull-up wrong");
    a_pull_down_cfg: assert property (o_pull_down_en == (c_q[4] & ~c_q[6] & c_q[5]))
        else $error("pull-down wrong");
    a_read_ctrl: assert property (i_reg_rd |=> (o_reg_rdata & 8'hf7) == $past(c_q))
        else $error("read data wrong");
    a_irq_needs_en: assert property (o_irq_req |-> c_q[1]) else $error("request while disabled");
    a_pin_off_quiet: assert property (!c_q[4] && !o_irq_req && !i_reg_wr |=> !o_irq_req)
        else $error("event while pin off");
    a_ack_clears: assert property (i_reg_wr && i_reg_wdata[2] && !c_q[4] |=> !o_irq_req)
        else $error("ack ignored");
    // eight cycles covers the synchroniser and the flag stage
    a_level_holds: assert property ((c_q[4] && c_q[1] && c_q[0] && i_pin == c_q[5]) [*8] |-> o_irq_req)
        else $error("level request lost");
    a_vector_fixed: assert property (o_vector_num == 8'h02 && o_vector_addr == 16'hfffa)
        else $error("vector wrong");
    c_level_req: cover property (c_q[0] && o_irq_req);
    c_edge_req: cover property (!c_q[0] && $rose(o_irq_req));
    c_polled: cover property (!c_q[1] && c_q[4] && i_reg_rd);
endmodule
bind eirq_detector eirq_detector_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_pin), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_irq_req(o_irq_req),
    .o_vector_num(o_vector_num), .o_vector_addr(o_vector_addr), .o_pull_up_en(o_pull_up_en),
    .o_pull_down_en(o_pull_down_en));
`default_nettype wire

/* verif/eirq_pin_drv.sv */
// Purpose: far-side device on the request pin
// Assumes: it drives the pin or leaves it to the pad pulls
// Notes:   an unpulled floating pin never holds its value
`default_nettype none
module eirq_pin_drv (
    input  wire logic i_clk,
    input  wire logic i_drv_en,
    input  wire logic i_drv_val,
    input  wire logic i_pull_up_en,
    input  wire logic i_pull_down_en,
    output logic      o_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_q = 1'b0;
    // released pin takes the pull, else flips so no stale level passes
    always @(posedge i_clk) last_q <= o_pin;
    assign o_pin = i_drv_en ? i_drv_val : (i_pull_up_en | (~i_pull_down_en & ~last_q));
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: self-checking bench for the pin interrupt detector
// Assumes: register reached by one-cycle write and read strobes
// Notes:   st holds steps {op, value}; ctrl and flag are the model
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, drv_en = 1'b1, drv_val = 1'b1;
    logic        pin, irq, pu, pd;
    logic [7:0]  i_reg_wdata = 8'h00, rdata, v;
    int          n_errors = 0, cmp_count = 0, ctrl = 0, flag = 0, seed = 32'h7b7f;
    // ops: 1 write, 2 read, 3 pin, 4 reset, 5 idle, 6 set model flag, 7 irq check, 8 report, 9 pin noise,
    // a random config
    int          st[$] = '{'h2ff, 'h801, 'ha08, 'h150, 'h2f7, 'h100, 'h506, 'h104, 'h2ff, 'h802,
        'h112, 'h300, 'h508, 'h601, 'h701, 'h2ff, 'h112, 'h2ff, 'h116, 'h700, 'h2ff, 'h803,
        'h133, 'h301, 'h508, 'h601, 'h701, 'h137, 'h503, 'h701, 'h2ff,
        'h300, 'h506, 'h137, 'h700, 'h804, 'h301, 'h506, 'h110, 'h300, 'h508, 'h601, 'h700, 'h2ff,
        'h106, 'h900, 'h506, 'h700, 'h2ff, 'h132, 'h400, 'h2ff, 'h805};
    always #10 i_clk = ~i_clk;
    eirq_pin_drv u_far (.i_clk(i_clk), .i_drv_en(drv_en), .i_drv_val(drv_val), .i_pull_up_en(pu),
        .i_pull_down_en(pd), .o_pin(pin));
    eirq_detector DUT (.i_clk(i_clk), .i_rst(i_rst), .i_pin(pin), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata), .o_irq_req(irq), .o_vector_num(),
        .o_vector_addr(), .o_pull_up_en(pu), .o_pull_down_en(pd));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) n_errors++;
        if (seen !== exp) $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ack fails in level mode while the pin sits at its asserted level
    task automatic wr(input logic [7:0] w);
        @(posedge i_clk) {i_reg_wr, i_reg_wdata} <= {1'b1, w};
        @(posedge i_clk) i_reg_wr <= 1'b0;
        if (w[2] && !(w[0] && drv_val == w[5])) flag = 0;
        ctrl = w & 8'h73;
    endtask
    task automatic rd(input logic [7:0] m);
        @(posedge i_clk) i_reg_rd <= 1'b1;
        @(posedge i_clk) i_reg_rd <= 1'b0;
        #1;
        chk({pu, pd, rdata & m}, {ctrl[4] & ~ctrl[6] & ~ctrl[5], ctrl[4] & ~ctrl[6] & ctrl[5],
            8'(ctrl | (flag << 3)) & m});
    endtask
    // cut a hang short
    initial begin
        repeat (3000) @(posedge i_clk);
        n_errors++;
        close_out();
    end
    // reset, then walk the step table
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (st[i]) begin
            v = 8'(st[i]);
            case (st[i][11:8])
                4'h1: wr(v);
                4'h2: rd(v);
                4'h3: @(posedge i_clk) drv_val <= v[0];
                // mid-run reset: every control bit and the flag must return to zero
                4'h4: begin
                    @(posedge i_clk) i_rst <= 1'b1;
                    repeat (4) @(posedge i_clk);
                    i_rst <= 1'b0;
                    ctrl = 0;
                    flag = 0;
                end
                4'h5: repeat (v) @(posedge i_clk);
                4'h6: flag = v;
                4'h7: chk(24'(irq), 24'(v[0]));
                4'h8: $display("test %0d done", v);
                4'h9: repeat (20) @(posedge i_clk) {drv_en, drv_val} <= 2'($random(seed));
                4'ha: repeat (v) begin
                    wr(8'($random(seed)) & 8'hfe);
                    rd(8'hf7);
                end
            endcase
            #1;
        end
        close_out();
    end
endmodule
`default_nettype wire
